/* shared/dac_slope_params.svh */
// Offsets, field positions, reset values and limits of the DAC comparator slope block
`ifndef DAC_SLOPE_PARAMS_SVH
`define DAC_SLOPE_PARAMS_SVH

// ==========================================================
// Register byte addresses
`define OFS_CHAN_CTRL_LOW    8'h00
`define OFS_CHAN_CTRL_HIGH   8'h04
`define OFS_UPPER_LIMIT      8'h08
`define OFS_LOWER_LIMIT      8'h0c
`define OFS_RAMP_CTRL_HIGH   8'h10
`define OFS_RAMP_CTRL_LOW    8'h14
`define OFS_RAMP_RATE        8'h18
`define OFS_RAMP_STATUS      8'h1c

// ==========================================================
// Field positions, channel control low
`define POS_CHANNEL_ENABLE   15
`define POS_IRQ_MODE_LSB     13
`define POS_BLANK_ENABLE     10
`define POS_ROUTE_ENABLE     9
`define POS_FILTER_ENABLE    8
`define POS_COMP_STATE       7
`define POS_COMP_INVERT      6
`define POS_COMPARATOR_INPUT_SELECT_LSB        3
`define POS_HYS_EDGE         2
`define POS_HYS_AMT_LSB      0

// ==========================================================
// Field positions, ramp control high
`define POS_RAMP_ENABLE      15
`define POS_HYST_MODE        11
`define POS_TRI_MODE         10
`define POS_RAMP_UP          9

// ==========================================================
// Field positions, ramp control low
`define POS_HCF_LSB          12
`define POS_STOPA_LSB        8
`define POS_STOPB_LSB        4
`define POS_START_LSB        0

// ==========================================================
// Write masks and reset values
`define MASK_CHAN_CTRL_LOW   16'he77f
`define MASK_CHAN_CTRL_HIGH  16'h03ff
`define MASK_LIMIT           16'h0fff
`define MASK_RAMP_CTRL_HIGH  16'h8e00
`define RESET_REG16          16'h0000

// ==========================================================
// Select codes, filter length and bus answers
`define SEL_CONST_ONE_FIRST  4'hd
`define SEL_HCF_ONE          4'hf
`define SEL_CMP_ONE_FIRST    4'h4
`define COMPARATOR_INPUT_SELECT_LAST_VALID     3'h3
`define FILTER_SAMPLES       3
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

/* shared/dac_slope_pkg.sv */
// Types shared by the DAC comparator slope block
`default_nettype none
package dac_slope_pkg;

  // ==========================================================
  // Slope engine states
  typedef enum logic [1:0] {RAMP_IDLE, RAMP_RUN} ramp_state_t;

  // ==========================================================
  // Comparator analog setup carried to the comparator
  typedef struct packed {
    logic [2:0] comparator_input_select;
    logic       hysteresis_edge_select;
    logic [1:0] hysteresis_amount;
    logic       analog_output_route_enable;
  } analog_setup_t;

  // ==========================================================
  // PWM signals offered to the selectors
  typedef struct packed {
    logic [7:0] pwm_high;
    logic [7:0] pwm_trigger_first;
    logic [7:0] pwm_trigger_second;
    logic [2:0] comparator_outs;
  } pwm_sources_t;

endpackage
`default_nettype wire

/* hw/dac_comparator_slope_control.sv */
// DAC comparator control, limits and slope generator behind an AXI4-Lite slave
`include "dac_slope_params.svh"
`default_nettype none

// Overview of operation
// - Blank enable gates comparator output during recovery after slope completes.
// - Output route enable connects DAC voltage to the analog output pin.
// - Filter enable puts digital filter in comparator path, else bypassed.
// - Comparator state bit reads comparator output after polarity inversion.
// - Invert bit inverts comparator output; clear passes it unchanged.
// - Input select codes 0-3 pick inputs A-D; 4-7 reserved.
// - Hysteresis edge bit: set means falling edge, clear means rising edge.
// - Hysteresis amount: none, 15, 30 or 45 mV for codes 0-3.
// - Edge detection acts after polarity; mode changes may give spurious events.
// - Upper limit holds 12 bits, top four read zero; range 205-3890.
// - Lower limit supplies low value for hysteretic, slope and triangle modes.
// - Ramp enable clear stops slope and accumulator; set enables generation.
// - Direction bit set makes slope increase, clear makes it decrease.
// - Hysteretic control signal switches DAC source between upper and lower limit.
// - Each edge of hysteretic control flips polarity and starts blanking counter.
// - Hysteretic select: 1-8 PWM high outputs, 0 and 9-14 zero, 15 one.
// - Slope ends when either selected stop signal is asserted.
// - First stop select: 1-8 PWM second triggers, 0 zero, 13-15 one.
// - Second stop select: 1-3 comparator outputs, 0 zero, 4-15 one.
// - Start select: 1-8 PWM first triggers, 0 zero, 13-15 one.
// - Ramp rate is a 12.4 fixed-point step, left justified.
// - Channel enable clear disables channel and clears pending slope state.
// - Edge mode: 0 off, 1 rising, 2 falling, 3 either edge.
// - Blanking count sets blanking length after each hysteretic control edge and each slope completion.
module dac_comparator_slope_control
  import dac_slope_pkg::*;
(
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Comparator and PWM sources
  input  wire logic          comparator_raw,
  input  wire pwm_sources_t  sources,
  // Analog side
  output analog_setup_t      analog_setup,
  output logic [11:0]        dac_code,
  output logic               comparator_out,
  output logic               comparator_edge_event,
  output logic               blanking_active
);

  // ==========================================================
  // Helpers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] data,
                                          input logic [1:0] strb, input logic [15:0] mask);
    logic [15:0] m;
    m = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    merge16 = (old & ~m) | (data & m);
  endfunction

  function automatic logic pick_pwm(input logic [3:0] sel, input logic [7:0] vec,
                                    input logic [3:0] one_first);
    if (sel >= one_first) begin
      pick_pwm = 1'b1;
    end else if (sel >= 4'h1 && sel <= 4'h8) begin
      pick_pwm = vec[3'(sel - 4'h1)];
    end else begin
      pick_pwm = 1'b0;
    end
  endfunction

  // ==========================================================
  // Registers
  logic [15:0] chan_low_reg;
  logic [15:0] chan_high_reg;
  logic [15:0] upper_reg;
  logic [15:0] lower_reg;
  logic [15:0] ramp_high_reg;
  logic [15:0] ramp_low_reg;
  logic [15:0] rate_reg;

  // ==========================================================
  // Field decode
  wire logic       channel_enable        = chan_low_reg[`POS_CHANNEL_ENABLE];
  wire logic [1:0] interrupt_edge_mode   = chan_low_reg[`POS_IRQ_MODE_LSB +: 2];
  wire logic       blank_enable          = chan_low_reg[`POS_BLANK_ENABLE];
  wire logic       comparator_filter_enable = chan_low_reg[`POS_FILTER_ENABLE];
  wire logic       comparator_invert     = chan_low_reg[`POS_COMP_INVERT];
  wire logic [9:0] blanking_count        = chan_high_reg[9:0];
  wire logic [11:0] upper_limit_value    = upper_reg[11:0];
  wire logic [11:0] lower_limit_value    = lower_reg[11:0];
  wire logic       ramp_enable           = ramp_high_reg[`POS_RAMP_ENABLE];
  wire logic       hysteretic_mode_enable = ramp_high_reg[`POS_HYST_MODE];
  wire logic       triangle_mode_enable  = ramp_high_reg[`POS_TRI_MODE];
  wire logic       ramp_direction_up     = ramp_high_reg[`POS_RAMP_UP];
  wire logic [3:0] hysteretic_control_select = ramp_low_reg[`POS_HCF_LSB +: 4];
  wire logic [3:0] ramp_stop_first_select  = ramp_low_reg[`POS_STOPA_LSB +: 4];
  wire logic [3:0] ramp_stop_second_select = ramp_low_reg[`POS_STOPB_LSB +: 4];
  wire logic [3:0] ramp_begin_select     = ramp_low_reg[`POS_START_LSB +: 4];
  wire logic [15:0] ramp_step_value      = rate_reg;  // 12.4 step

  // ==========================================================
  // Analog setup pass-through
  assign analog_setup.comparator_input_select =
      (chan_low_reg[`POS_COMPARATOR_INPUT_SELECT_LSB +: 3] <= `COMPARATOR_INPUT_SELECT_LAST_VALID) ?
      chan_low_reg[`POS_COMPARATOR_INPUT_SELECT_LSB +: 3] : 3'h0;
  assign analog_setup.hysteresis_edge_select = chan_low_reg[`POS_HYS_EDGE];
  assign analog_setup.hysteresis_amount = chan_low_reg[`POS_HYS_AMT_LSB +: 2];
  assign analog_setup.analog_output_route_enable =
      channel_enable & chan_low_reg[`POS_ROUTE_ENABLE];

  // ==========================================================
  // Source selection
  wire logic hyst_ctrl = (hysteretic_control_select == `SEL_HCF_ONE) ? 1'b1 :
                         pick_pwm(hysteretic_control_select, sources.pwm_high,
                                  4'hf);
  wire logic stop_first = pick_pwm(ramp_stop_first_select,
                                   sources.pwm_trigger_second,
                                   `SEL_CONST_ONE_FIRST);
  wire logic stop_second = (ramp_stop_second_select >= `SEL_CMP_ONE_FIRST) ? 1'b1 :
                           (ramp_stop_second_select == 4'h0) ? 1'b0 :
                           sources.comparator_outs[2'(ramp_stop_second_select - 4'h1)];
  wire logic ramp_stop = stop_first | stop_second;
  wire logic ramp_start = pick_pwm(ramp_begin_select, sources.pwm_trigger_first,
                                   `SEL_CONST_ONE_FIRST);

  // ==========================================================
  // Comparator filter, polarity and blanking
  logic [`FILTER_SAMPLES-1:0] filt_shift_reg;
  logic        filt_reg;
  logic        hyst_ctrl_reg;
  logic        hyst_flip_reg;
  logic [9:0]  blank_cnt_reg;
  logic        state_reg;

  wire logic filt_all_one  = &filt_shift_reg;
  wire logic filt_all_zero = ~|filt_shift_reg;
  wire logic filt_next = filt_all_one ? 1'b1 : filt_all_zero ? 1'b0 : filt_reg;
  wire logic comp_path = comparator_filter_enable ? filt_reg : comparator_raw;
  wire logic state_next = comp_path ^ comparator_invert ^ hyst_flip_reg;
  wire logic hyst_edge = hysteretic_mode_enable & (hyst_ctrl ^ hyst_ctrl_reg);

  assign blanking_active = blank_enable & (blank_cnt_reg != 10'h000);
  assign comparator_out = state_reg & ~blanking_active;

  wire logic rise = state_next & ~state_reg;
  wire logic fall = ~state_next & state_reg;
  wire logic edge_hit = (interrupt_edge_mode[0] & rise) |
                        (interrupt_edge_mode[1] & fall);

  // ==========================================================
  // Slope engine
  ramp_state_t ramp_state_reg;
  ramp_state_t ramp_state_next;
  logic [15:0] acc_reg;
  logic [15:0] acc_next;
  logic        tri_up_reg;
  logic        tri_up_next;
  logic        ramp_done;

  wire logic [15:0] upper_fx = {upper_limit_value, 4'h0};
  wire logic [15:0] lower_fx = {lower_limit_value, 4'h0};
  wire logic [16:0] acc_plus  = {1'b0, acc_reg} + {1'b0, ramp_step_value};
  wire logic [16:0] acc_minus = {1'b0, acc_reg} - {1'b0, ramp_step_value};
  wire logic hit_upper = acc_plus[16] | (acc_plus[15:0] >= upper_fx);
  wire logic hit_lower = acc_minus[16] | (acc_minus[15:0] <= lower_fx);
  wire logic slope_ok = channel_enable & ramp_enable;

  always_comb begin
    ramp_state_next = ramp_state_reg;
    acc_next = acc_reg;
    tri_up_next = tri_up_reg;
    ramp_done = 1'b0;
    unique case (ramp_state_reg)
      RAMP_IDLE: begin
        if (slope_ok && ramp_start) begin
          ramp_state_next = RAMP_RUN;
          tri_up_next = ramp_direction_up;
          acc_next = ramp_direction_up ? lower_fx : upper_fx;
        end
      end
      RAMP_RUN: begin
        if (!slope_ok) begin
          ramp_state_next = RAMP_IDLE;
        end else if (ramp_stop) begin
          ramp_state_next = RAMP_IDLE;
          ramp_done = 1'b1;
        end else if (tri_up_reg) begin
          acc_next = hit_upper ? upper_fx : acc_plus[15:0];
          if (hit_upper && triangle_mode_enable) begin
            tri_up_next = 1'b0;
          end
        end else begin
          acc_next = hit_lower ? lower_fx : acc_minus[15:0];
          if (hit_lower && triangle_mode_enable) begin
            tri_up_next = 1'b1;
          end
        end
      end
    endcase
  end

  // ==========================================================
  // DAC source choice
  wire logic [11:0] dac_code_next =
      (ramp_state_reg == RAMP_RUN) ? acc_reg[15:4] :
      hysteretic_mode_enable ? (hyst_ctrl ? upper_limit_value : lower_limit_value) :
      upper_limit_value;

  // ==========================================================
  // Comparator and slope state flops
  always_ff @(posedge aclk) begin
    if (!aresetn || !channel_enable) begin
      filt_shift_reg <= '0;
      filt_reg <= 1'b0;
      hyst_ctrl_reg <= 1'b0;
      hyst_flip_reg <= 1'b0;
      blank_cnt_reg <= 10'h000;
      state_reg <= 1'b0;
      comparator_edge_event <= 1'b0;
      ramp_state_reg <= RAMP_IDLE;
      acc_reg <= 16'h0000;
      tri_up_reg <= 1'b0;
      dac_code <= 12'h000;
    end else begin
      filt_shift_reg <= {filt_shift_reg[`FILTER_SAMPLES-2:0], comparator_raw};
      filt_reg <= filt_next;
      hyst_ctrl_reg <= hyst_ctrl;
      if (hyst_edge) begin
        hyst_flip_reg <= ~hyst_flip_reg;
      end
      if (hyst_edge || ramp_done) begin
        blank_cnt_reg <= blanking_count;
      end else if (blank_cnt_reg != 10'h000) begin
        blank_cnt_reg <= blank_cnt_reg - 10'h001;
      end
      state_reg <= state_next;
      comparator_edge_event <= edge_hit;
      ramp_state_reg <= ramp_state_next;
      acc_reg <= acc_next;
      tri_up_reg <= tri_up_next;
      dac_code <= dac_code_next;
    end
  end

  // ==========================================================
  // AXI4-Lite write path
  logic        aw_held_reg;
  logic [7:0]  aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;

  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;

  wire logic        do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire logic [15:0] wd = w_data_reg[15:0];
  wire logic [1:0]  ws = w_strb_reg[1:0];
  wire logic        wr_hit = (aw_addr_reg[7:2] <= 6'(`OFS_RAMP_STATUS >> 2)) &&
                             (aw_addr_reg[1:0] == 2'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Register file
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_low_reg <= `RESET_REG16;
      chan_high_reg <= `RESET_REG16;
      upper_reg <= `RESET_REG16;
      lower_reg <= `RESET_REG16;
      ramp_high_reg <= `RESET_REG16;
      ramp_low_reg <= `RESET_REG16;
      rate_reg <= `RESET_REG16;
    end else if (do_write) begin
      unique case (aw_addr_reg)
        `OFS_CHAN_CTRL_LOW:  chan_low_reg  <= merge16(chan_low_reg, wd, ws,
                                                      `MASK_CHAN_CTRL_LOW);
        `OFS_CHAN_CTRL_HIGH: chan_high_reg <= merge16(chan_high_reg, wd, ws,
                                                      `MASK_CHAN_CTRL_HIGH);
        `OFS_UPPER_LIMIT:    upper_reg <= merge16(upper_reg, wd, ws, `MASK_LIMIT);
        `OFS_LOWER_LIMIT:    lower_reg <= merge16(lower_reg, wd, ws, `MASK_LIMIT);
        `OFS_RAMP_CTRL_HIGH: ramp_high_reg <= merge16(ramp_high_reg, wd, ws,
                                                      `MASK_RAMP_CTRL_HIGH);
        `OFS_RAMP_CTRL_LOW:  ramp_low_reg <= merge16(ramp_low_reg, wd, ws, 16'hffff);
        `OFS_RAMP_RATE:      rate_reg <= merge16(rate_reg, wd, ws, 16'hffff);
        default: ;
      endcase
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  logic [15:0] rd_word;
  logic        rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      `OFS_CHAN_CTRL_LOW:  rd_word = {chan_low_reg[15:8], state_reg, chan_low_reg[6:0]};
      `OFS_CHAN_CTRL_HIGH: rd_word = chan_high_reg;
      `OFS_UPPER_LIMIT:    rd_word = upper_reg;
      `OFS_LOWER_LIMIT:    rd_word = lower_reg;
      `OFS_RAMP_CTRL_HIGH: rd_word = ramp_high_reg;
      `OFS_RAMP_CTRL_LOW:  rd_word = ramp_low_reg;
      `OFS_RAMP_RATE:      rd_word = rate_reg;
      `OFS_RAMP_STATUS:    rd_word = {2'h0, blank_cnt_reg, 1'b0, blanking_active,
                                      tri_up_reg, ramp_state_reg == RAMP_RUN};
      default: begin
        rd_word = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_word};
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // dac_comparator_slope_control
`default_nettype wire

/* dv/dac_slope_monitor.sv */
// Bus and comparator checks for the DAC comparator slope block
`default_nettype none
module dac_slope_monitor
  import dac_slope_pkg::*;
(
  // Clock and reset
  input wire logic          aclk,
  input wire logic          aresetn,
  // Register bus
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  // Analog side
  input wire analog_setup_t analog_setup,
  input wire logic          comparator_out,
  input wire logic          blanking_active
);
  // ====
  // Properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_write_answer; s_write_taken |-> ##[1:2] s_axi_bvalid; endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer late");
  property p_read_answer; s_axi_arvalid && s_axi_arready |=> ##[0:1] s_axi_rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_wbusy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_wbusy: assert property (p_wbusy) else $error("write taken while busy");
  property p_rbusy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_rbusy: assert property (p_rbusy) else $error("read taken while busy");
  property p_blank; blanking_active |-> !comparator_out; endproperty
  a_blank: assert property (p_blank) else $error("output not blanked");
  property p_comparator_input_select; analog_setup.comparator_input_select[2] == 1'b0; endproperty
  a_comparator_input_select: assert property (p_comparator_input_select) else $error("reserved input chosen");
  property p_top; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0; endproperty
  a_top: assert property (p_top) else $error("upper bits not zero");
endmodule // dac_slope_monitor
bind dac_comparator_slope_control dac_slope_monitor u_dac_slope_monitor (.*);
`default_nettype wire

/* dv/pwm_source_model.sv */
// PWM trigger and comparator source model
`default_nettype none
module pwm_source_model
  import dac_slope_pkg::*;
(
  // Clock
  input  wire logic   aclk,
  // Bench requests
  input  wire logic [2:0] req,
  input  wire logic   cmp_level,
  // Toward the block
  output pwm_sources_t sources,
  output logic        comparator_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sources = '0;
    comparator_raw = 1'b0;
  end
  always @(posedge aclk) begin
    sources.pwm_trigger_first  <= {7'h0, req[0]};
    sources.pwm_trigger_second <= {7'h0, req[1]};
    sources.pwm_high           <= {7'h0, req[2]};
    sources.comparator_outs    <= {2'h0, req[1]};
    comparator_raw             <= cmp_level;
  end
endmodule // pwm_source_model
`default_nettype wire

/* dv/dac_comparator_slope_control_tb.sv */
// Self-checking bench for the DAC comparator slope block
`default_nettype none
module dac_comparator_slope_control_tb
  import dac_slope_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, cmp_level = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] req = 3'h0;
  logic comparator_raw, comparator_out, comparator_edge_event, blanking_active;
  logic [11:0] dac_code;
  pwm_sources_t sources;
  analog_setup_t analog_setup;
  int errors = 0, n_checks = 0, n_ev = 0;
  dac_comparator_slope_control u_dac_comparator_slope_control (.*);
  pwm_source_model u_pwm_source_model (.*);
  always #20 aclk = ~aclk;
  always @(posedge aclk) if (comparator_edge_event === 1'b1) n_ev++;
  // ====
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {16'h0, d});
    chk(s_axi_rresp, er);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wait_dac(input logic [11:0] e);
    for (int i = 0; i < 400 && dac_code !== e; i++) @(posedge aclk);
    chk(dac_code, e);
  endtask
  task automatic fire(input int b);
    @(posedge aclk); req[b] <= 1'b1;
    @(posedge aclk); req[b] <= 1'b0;
  endtask
  // ====
  // Scenarios
  task automatic t_regs;
    for (int a = 8; a <= 24; a += 4) rd(a[7:0], 16'h0);
    rd(8'h20, 16'h0, 2'h2);
    wr(8'h20, 16'h1234, 2'h2);
    wr(8'h08, 16'hffff); rd(8'h08, 16'h0fff);
  endtask
  task automatic t_comp;
    cmp_level <= 1'b1; wr(8'h00, 16'h8040); idle(12); rd(8'h00, 16'h8040);
    wr(8'h00, 16'h8000); idle(12); rd(8'h00, 16'h8080);
    chk(comparator_out, 1'b1);
    wr(8'h00, 16'h0228); chk(analog_setup.analog_output_route_enable, 1'b0);
    wr(8'h00, 16'h8228); chk(analog_setup, {3'h0, 1'b0, 2'h0, 1'b1});
    wr(8'h00, 16'h831f); chk(analog_setup, {3'h3, 1'b1, 2'h3, 1'b1});
  endtask
  task automatic t_edge;
    int exp[4] = '{0, 1, 1, 2};
    cmp_level <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, {1'b1, m[1:0], 13'h0}); idle(8); n_ev = 0;
      cmp_level <= 1'b1; idle(8); cmp_level <= 1'b0; idle(8);
      chk(n_ev, exp[m]);
    end
    wr(8'h00, 16'he100); idle(8); n_ev = 0;
    cmp_level <= 1'b1; idle(1); cmp_level <= 1'b0; idle(8);
    chk(n_ev, 0);
  endtask
  task automatic t_slope;
    wr(8'h08, 16'h0f32); wr(8'h0c, 16'h00cd); wr(8'h18, 16'h0100);
    wr(8'h14, 16'h0101); wr(8'h10, 16'h0000); wr(8'h00, 16'h8000);
    fire(0); idle(20); chk(dac_code, 12'hf32);
    wr(8'h10, 16'h8000); fire(0); wait_dac(12'hf22); wait_dac(12'h0cd);
    fire(1); wait_dac(12'hf32);
    wr(8'h10, 16'h8200); fire(0); wait_dac(12'h0dd);
    wr(8'h14, 16'h0011); fire(1); rd(8'h1c, 16'h0002);
    wr(8'h00, 16'h0000); wait_dac(12'h000);
    wr(8'h00, 16'h8000); wr(8'h14, 16'h0d01); fire(0); idle(20);
    chk(dac_code, 12'hf32);
  endtask
  task automatic t_hyst;
    wr(8'h00, 16'h8400); wr(8'h04, 16'h0010);
    wr(8'h10, 16'h0800); wr(8'h14, 16'h1000);
    req[2] <= 1'b1; wait_dac(12'hf32);
    chk(blanking_active, 1'b1);
    req[2] <= 1'b0; wait_dac(12'h0cd);
    wr(8'h14, 16'hf000); wait_dac(12'hf32);
    wr(8'h14, 16'h9000); wait_dac(12'h0cd);
  endtask
  task automatic t_tri;
    wr(8'h14, 16'h0001); wr(8'h10, 16'h8600); fire(0);
    wait_dac(12'hf32); wait_dac(12'h0cd); wait_dac(12'h0dd);
    wr(8'h10, 16'h0000); wait_dac(12'hf32);
  endtask
  // ====
  // Run control
  task automatic stop_test;
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs; t_comp; t_edge; t_slope; t_hyst; t_tri;
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    stop_test;
  end
endmodule // dac_comparator_slope_control_tb
`default_nettype wire
